// ==== rtl/cpwm_defines.vh ====
// register indices, field positions, reset values and mode codes of the compare/pwm unit
`ifndef CPWM_DEFINES_VH
`define CPWM_DEFINES_VH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define CPWM_IDX_INTERRUPT_CONTROL      8'h0b
`define CPWM_IDX_PERIPHERAL_IRQ_FLAGS   8'h0c
`define CPWM_IDX_TIMER1_COUNT_LOW       8'h0e
`define CPWM_IDX_TIMER1_COUNT_HIGH      8'h0f
`define CPWM_IDX_TIMER1_CONTROL         8'h10
`define CPWM_IDX_TIMER2_COUNT           8'h11
`define CPWM_IDX_TIMER2_CONTROL         8'h12
`define CPWM_IDX_MATCH_VALUE_LOW        8'h15
`define CPWM_IDX_MATCH_VALUE_HIGH       8'h16
`define CPWM_IDX_UNIT_CONTROL           8'h17
`define CPWM_IDX_PORT_B_DIRECTION       8'h86
`define CPWM_IDX_PERIPHERAL_IRQ_ENABLES 8'h8c
`define CPWM_IDX_TIMER2_PERIOD          8'h92

// ----------------------------------------
// reset values
// ----------------------------------------
`define CPWM_RST_INTERRUPT_CONTROL      8'h00
`define CPWM_RST_PERIPHERAL_IRQ_FLAGS   8'h00
`define CPWM_RST_TIMER1_CONTROL         8'h00
`define CPWM_RST_TIMER2_CONTROL         8'h00
`define CPWM_RST_MATCH_VALUE            8'h00
`define CPWM_RST_UNIT_CONTROL           8'h00
`define CPWM_RST_PORT_B_DIRECTION       8'hff
`define CPWM_RST_PERIPHERAL_IRQ_ENABLES 8'h00
`define CPWM_RST_TIMER2_PERIOD          8'hff

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define CPWM_BIT_GLOBAL_IE     7
`define CPWM_BIT_PERIPH_IE     6
`define CPWM_BIT_UNIT_FLAG     2
`define CPWM_BIT_T2_FLAG       1
`define CPWM_BIT_T1_FLAG       0
`define CPWM_BIT_T1_ON         0
`define CPWM_BIT_T2_ON         2
`define CPWM_MASK_7BIT         8'h7f
`define CPWM_MASK_UNIT_CONTROL 8'h3f

// ----------------------------------------
// mode select codes
// ----------------------------------------
`define CPWM_MODE_OFF          4'h0
`define CPWM_MODE_CMP_SET      4'h8
`define CPWM_MODE_CMP_CLEAR    4'h9
`define CPWM_MODE_CMP_SOFT     4'ha
`define CPWM_MODE_CMP_SPECIAL  4'hb
`define CPWM_MODE_CMP_PREFIX   2'h2
`define CPWM_MODE_PWM_PREFIX   2'h3

// ----------------------------------------
// timing: one timer tick is four oscillator periods (clk cycles)
// ----------------------------------------
`define CPWM_Q_LAST            2'h3

`endif

// ==== rtl/cpwm_timer1.v ====
// 16-bit timer with prescaler 1/2/4/8, clearable by the special event trigger
`timescale 1ns/1ns
module cpwm_timer1 (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        q_tick,
  input  wire        on,
  input  wire [1:0]  prescale_sel,
  input  wire        wr_low,
  input  wire        wr_high,
  input  wire [7:0]  wr_data,
  input  wire        clear,
  output reg  [15:0] count_ff,
  output wire        overflow
);
  reg  [2:0] pre_ff;
  wire [2:0] pre_last = (3'h1 << prescale_sel) - 3'h1;
  wire       inc      = on & q_tick & (pre_ff == pre_last);

  // special event clear is not a wrap, so no overflow flag from it
  assign overflow = inc & (count_ff == 16'hffff) & ~clear;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff   <= 3'h0;
      count_ff <= 16'h0000;
    end else if (clear) begin
      pre_ff   <= 3'h0;
      count_ff <= 16'h0000;
    end else if (wr_low) begin
      pre_ff   <= 3'h0;
      count_ff <= {count_ff[15:8], wr_data};
    end else if (wr_high) begin
      pre_ff   <= 3'h0;
      count_ff <= {wr_data, count_ff[7:0]};
    end else begin
      if (on & q_tick)
        pre_ff <= (pre_ff == pre_last) ? 3'h0 : pre_ff + 3'h1;
      if (inc)
        count_ff <= count_ff + 16'h0001;
    end
  end
endmodule

// ==== rtl/cpwm_timer2.v ====
// 8-bit pwm time base: prescaler 1/4/16, period match, postscaled flag
`timescale 1ns/1ns
module cpwm_timer2 (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       q_tick,
  input  wire [1:0] q_phase,
  input  wire       on,
  input  wire [1:0] prescale_sel,
  input  wire [3:0] postscale_sel,
  input  wire [7:0] period,
  input  wire       wr_count,
  input  wire [7:0] wr_data,
  output reg  [7:0] count_ff,
  output wire [1:0] frac,
  output wire       rollover,
  output wire       flag_pulse
);
  reg  [3:0] pre_ff;
  reg  [3:0] post_ff;
  wire [3:0] pre_last = (prescale_sel == 2'h0) ? 4'h0 : (prescale_sel == 2'h1) ? 4'h3 : 4'hf;
  wire       inc      = on & q_tick & (pre_ff == pre_last);

  assign rollover   = inc & (count_ff == period);
  // postscaler only thins the flag; rollover itself stays unscaled
  assign flag_pulse = rollover & (post_ff == postscale_sel);
  // sub-step position extends the count to ten bits
  assign frac = (prescale_sel == 2'h0) ? q_phase :
                (prescale_sel == 2'h1) ? pre_ff[1:0] : pre_ff[3:2];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff   <= 4'h0;
      post_ff  <= 4'h0;
      count_ff <= 8'h00;
    end else begin
      if (wr_count) begin
        pre_ff   <= 4'h0;
        count_ff <= wr_data;
      end else begin
        if (on & q_tick)
          pre_ff <= (pre_ff == pre_last) ? 4'h0 : pre_ff + 4'h1;
        if (inc)
          count_ff <= rollover ? 8'h00 : count_ff + 8'h01;
      end
      if (rollover)
        post_ff <= (post_ff == postscale_sel) ? 4'h0 : post_ff + 4'h1;
    end
  end
endmodule

// ==== rtl/cpwm_unit.v ====
// compare and pwm unit with its timers, flags and apb register file
// What this block does
// - compare modes check the 16-bit match value against timer1 all the time
// - on match drive pin high, low or keep it, and set the unit flag together
// - writing zero to unit control forces the compare output latch low
// - flag-only mode leaves the pin alone and raises the interrupt if enabled
// - special event match clears timer1 and starts a conversion if converter enabled
// - the special event clear never sets the timer1 overflow flag
// - pwm mode drives a waveform with up to ten bits of duty resolution
// - writing zero to unit control forces the pwm output latch low
// - pwm period is (period value + 1) x 4 clocks x timer2 prescale
// - on the timer2 increment after count equals period, clear count and load duty
// - each rollover sets the pin, unless the duty value is zero
// - the timer2 postscaler does not change the pwm frequency
// - duty is match low as eight high bits plus control bits 5:4
// - duty writes accepted any time, applied only at the next period match
// - in pwm mode the match high register is read-only
// - pin clears when active duty equals timer2 extended by two sub-step bits
// - duty larger than the period never clears the pin
// - the timer2 prescaler divides by 1, 4 or 16
`timescale 1ns/1ns
`include "cpwm_defines.vh"
module cpwm_unit #(
  parameter ADDR_W = 12
) (
  input  wire              CLK,
  input  wire              RESET_N,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [ADDR_W-1:0] PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  input  wire              ADC_ENABLE,
  input  wire              PIN_LOCATION_CONFIG,
  output reg               UNIT_OUTPUT_PIN,
  output reg               UNIT_PIN_OE_N,
  output reg               ADC_START,
  output reg               PERIPH_IRQ
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function hit;
    input [ADDR_W-1:0] addr;
    input [7:0]        idx;
    begin
      hit = (addr == {{(ADDR_W-10){1'b0}}, idx, 2'b00});
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]  interrupt_control_ff;
  reg  [6:0]  irq_flags_ff;
  reg  [6:0]  irq_enables_ff;
  reg  [6:0]  timer1_control_ff;
  reg  [6:0]  timer2_control_ff;
  reg  [7:0]  match_value_low_ff;
  reg  [7:0]  match_value_high_ff;
  reg  [5:0]  unit_control_ff;
  reg  [7:0]  port_b_direction_ff;
  reg  [7:0]  timer2_period_ff;
  reg  [1:0]  duty_low_latch_ff;
  reg  [1:0]  q_ff;
  reg         match_seen_ff;
  reg         period_start_ff;

  reg  [6:0]  nxt_irq_flags;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         nxt_pin;

  wire [15:0] timer1_count;
  wire        timer1_overflow;
  wire [7:0]  timer2_count;
  wire [1:0]  timer2_frac;
  wire        timer2_rollover;
  wire        timer2_flag;

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  wire        access   = PSEL & PENABLE & PREADY;
  wire        wr       = access & PWRITE & ~PSLVERR;
  wire [7:0]  wdata    = PWDATA[7:0];

  wire wr_interrupt_control    = wr & hit(PADDR, `CPWM_IDX_INTERRUPT_CONTROL);
  wire wr_flags     = wr & hit(PADDR, `CPWM_IDX_PERIPHERAL_IRQ_FLAGS);
  wire wr_t1_low    = wr & hit(PADDR, `CPWM_IDX_TIMER1_COUNT_LOW);
  wire wr_t1_high   = wr & hit(PADDR, `CPWM_IDX_TIMER1_COUNT_HIGH);
  wire wr_t1_ctrl   = wr & hit(PADDR, `CPWM_IDX_TIMER1_CONTROL);
  wire wr_t2_count  = wr & hit(PADDR, `CPWM_IDX_TIMER2_COUNT);
  wire wr_t2_ctrl   = wr & hit(PADDR, `CPWM_IDX_TIMER2_CONTROL);
  wire wr_match_lo  = wr & hit(PADDR, `CPWM_IDX_MATCH_VALUE_LOW);
  wire wr_match_hi  = wr & hit(PADDR, `CPWM_IDX_MATCH_VALUE_HIGH);
  wire wr_unit_ctrl = wr & hit(PADDR, `CPWM_IDX_UNIT_CONTROL);
  wire wr_dir       = wr & hit(PADDR, `CPWM_IDX_PORT_B_DIRECTION);
  wire wr_enables   = wr & hit(PADDR, `CPWM_IDX_PERIPHERAL_IRQ_ENABLES);
  wire wr_period    = wr & hit(PADDR, `CPWM_IDX_TIMER2_PERIOD);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire [3:0] mode     = unit_control_ff[3:0];
  wire       pwm_mode = (mode[3:2] == `CPWM_MODE_PWM_PREFIX);
  wire       cmp_mode = (mode[3:2] == `CPWM_MODE_CMP_PREFIX);
  wire       q_tick   = (q_ff == `CPWM_Q_LAST);

  // ----------------------------------------
  // compare path
  // ----------------------------------------
  // the timer holds a value for several clocks; fire once per match
  wire match     = cmp_mode & (timer1_count == {match_value_high_ff, match_value_low_ff});
  wire cmp_event = match & ~match_seen_ff;
  wire special   = cmp_event & (mode == `CPWM_MODE_CMP_SPECIAL);

  // ----------------------------------------
  // pwm path
  // ----------------------------------------
  wire [9:0] duty_buffered = {match_value_low_ff, unit_control_ff[5:4]};
  wire [9:0] duty_active   = {match_value_high_ff, duty_low_latch_ff};
  wire       period_start  = pwm_mode & timer2_rollover;
  // duty above the period is never reached, so the pin stays high
  wire       duty_end      = pwm_mode & ({timer2_count, timer2_frac} == duty_active);

  // ----------------------------------------
  // pwm pin timing
  // ----------------------------------------
  // the pin flop lands the fall one clock after the duty sub-step is reached;
  // the rise is taken from the delayed rollover so the high time is exact
  // mode guard: leaving pwm in the rollover clock must not set the pin
  wire       pwm_rise      = pwm_mode & period_start_ff;
  wire       duty_nonzero  = (duty_active != 10'h000);

  // ----------------------------------------
  // timers
  // ----------------------------------------
  // timer1 counts internal ticks only, so the compare sees a synchronous count
  cpwm_timer1 u_timer1 (
    .clk          (CLK),
    .reset_n      (RESET_N),
    .q_tick       (q_tick),
    .on           (timer1_control_ff[`CPWM_BIT_T1_ON]),
    .prescale_sel (timer1_control_ff[5:4]),
    .wr_low       (wr_t1_low),
    .wr_high      (wr_t1_high),
    .wr_data      (wdata),
    .clear        (special),
    .count_ff     (timer1_count),
    .overflow     (timer1_overflow)
  );

  // period = (period + 1) ticks of four clocks times the prescale
  cpwm_timer2 u_timer2 (
    .clk           (CLK),
    .reset_n       (RESET_N),
    .q_tick        (q_tick),
    .q_phase       (q_ff),
    .on            (timer2_control_ff[`CPWM_BIT_T2_ON]),
    .prescale_sel  (timer2_control_ff[1:0]),
    .postscale_sel (timer2_control_ff[6:3]),
    .period        (timer2_period_ff),
    .wr_count      (wr_t2_count),
    .wr_data       (wdata),
    .count_ff      (timer2_count),
    .frac          (timer2_frac),
    .rollover      (timer2_rollover),
    .flag_pulse    (timer2_flag)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always @* begin
    nxt_irq_flags = wr_flags ? wdata[6:0] : irq_flags_ff;
    // hardware set wins over a software clear in the same cycle
    if (cmp_event)
      nxt_irq_flags[`CPWM_BIT_UNIT_FLAG] = 1'b1;
    if (timer2_flag)
      nxt_irq_flags[`CPWM_BIT_T2_FLAG] = 1'b1;
    if (timer1_overflow)
      nxt_irq_flags[`CPWM_BIT_T1_FLAG] = 1'b1;
  end

  always @* begin
    nxt_pin = UNIT_OUTPUT_PIN;
    if (wr_unit_ctrl && wdata == 8'h00) begin
      nxt_pin = 1'b0;
    end else if (mode == `CPWM_MODE_OFF) begin
      nxt_pin = 1'b0;
    end else if (cmp_event) begin
      if (mode == `CPWM_MODE_CMP_SET)
        nxt_pin = 1'b1;
      else if (mode == `CPWM_MODE_CMP_CLEAR)
        nxt_pin = 1'b0;
      else
        nxt_pin = UNIT_OUTPUT_PIN;
    end else if (pwm_rise) begin
      nxt_pin = duty_nonzero;
    end else if (duty_end) begin
      nxt_pin = 1'b0;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      interrupt_control_ff <= `CPWM_RST_INTERRUPT_CONTROL;
      irq_flags_ff         <= 7'h00;
      irq_enables_ff       <= 7'h00;
      timer1_control_ff    <= 7'h00;
      timer2_control_ff    <= 7'h00;
      match_value_low_ff   <= `CPWM_RST_MATCH_VALUE;
      match_value_high_ff  <= `CPWM_RST_MATCH_VALUE;
      unit_control_ff      <= 6'h00;
      port_b_direction_ff  <= `CPWM_RST_PORT_B_DIRECTION;
      timer2_period_ff     <= `CPWM_RST_TIMER2_PERIOD;
      duty_low_latch_ff    <= 2'h0;
      q_ff                 <= 2'h0;
      match_seen_ff        <= 1'b0;
      period_start_ff      <= 1'b0;
    end else begin
      q_ff          <= q_ff + 2'h1;
      match_seen_ff <= match;
      period_start_ff <= period_start;
      irq_flags_ff  <= nxt_irq_flags;
      if (wr_interrupt_control)
        interrupt_control_ff <= wdata;
      if (wr_enables)
        irq_enables_ff <= wdata[6:0];
      if (wr_t1_ctrl)
        timer1_control_ff <= wdata[6:0];
      if (wr_t2_ctrl)
        timer2_control_ff <= wdata[6:0];
      if (wr_dir)
        port_b_direction_ff <= wdata;
      if (wr_period)
        timer2_period_ff <= wdata;
      if (wr_unit_ctrl)
        unit_control_ff <= wdata[5:0];
      // buffered duty may change any time; active copy waits for rollover
      if (wr_match_lo)
        match_value_low_ff <= wdata;
      if (period_start) begin
        match_value_high_ff <= duty_buffered[9:2];
        duty_low_latch_ff   <= duty_buffered[1:0];
      end else if (wr_match_hi && !pwm_mode) begin
        match_value_high_ff <= wdata;
      end
    end
  end

  // ----------------------------------------
  // pins and side outputs
  // ----------------------------------------
  // the direction bit moves between two port bits with the pin location
  wire       dir_bit       = PIN_LOCATION_CONFIG ? port_b_direction_ff[3] : port_b_direction_ff[0];
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      UNIT_OUTPUT_PIN <= 1'b0;
      UNIT_PIN_OE_N   <= 1'b1;
      ADC_START       <= 1'b0;
      PERIPH_IRQ      <= 1'b0;
    end else begin
      UNIT_OUTPUT_PIN <= nxt_pin;
      // pin only driven once software clears its direction bit
      UNIT_PIN_OE_N   <= dir_bit;
      ADC_START       <= special & ADC_ENABLE;
      PERIPH_IRQ      <= interrupt_control_ff[`CPWM_BIT_GLOBAL_IE] &
                         interrupt_control_ff[`CPWM_BIT_PERIPH_IE] &
                         (|(irq_flags_ff & irq_enables_ff));
    end
  end

  // ----------------------------------------
  // apb read mux
  // ----------------------------------------
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (hit(PADDR, `CPWM_IDX_INTERRUPT_CONTROL))
      rd_data[7:0] = interrupt_control_ff;
    else if (hit(PADDR, `CPWM_IDX_PERIPHERAL_IRQ_FLAGS))
      rd_data[6:0] = irq_flags_ff;
    else if (hit(PADDR, `CPWM_IDX_TIMER1_COUNT_LOW))
      rd_data[7:0] = timer1_count[7:0];
    else if (hit(PADDR, `CPWM_IDX_TIMER1_COUNT_HIGH))
      rd_data[7:0] = timer1_count[15:8];
    else if (hit(PADDR, `CPWM_IDX_TIMER1_CONTROL))
      rd_data[6:0] = timer1_control_ff;
    else if (hit(PADDR, `CPWM_IDX_TIMER2_COUNT))
      rd_data[7:0] = timer2_count;
    else if (hit(PADDR, `CPWM_IDX_TIMER2_CONTROL))
      rd_data[6:0] = timer2_control_ff;
    else if (hit(PADDR, `CPWM_IDX_MATCH_VALUE_LOW))
      rd_data[7:0] = match_value_low_ff;
    else if (hit(PADDR, `CPWM_IDX_MATCH_VALUE_HIGH))
      rd_data[7:0] = match_value_high_ff;
    else if (hit(PADDR, `CPWM_IDX_UNIT_CONTROL))
      rd_data[5:0] = unit_control_ff;
    else if (hit(PADDR, `CPWM_IDX_PORT_B_DIRECTION))
      rd_data[7:0] = port_b_direction_ff;
    else if (hit(PADDR, `CPWM_IDX_PERIPHERAL_IRQ_ENABLES))
      rd_data[6:0] = irq_enables_ff;
    else if (hit(PADDR, `CPWM_IDX_TIMER2_PERIOD))
      rd_data[7:0] = timer2_period_ff;
    else
      rd_err = 1'b1;
  end

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // answer prepared in the setup cycle: one access cycle, no wait states
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & rd_err;
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= rd_data;
    end
  end

endmodule

// ==== sim/cpwm_pin_model.sv ====
// output pad with pull-down, waveform meter and converter start counter
`timescale 1ns/1ns
module cpwm_pin_model (
  input  wire        clk,
  input  wire        pin,
  input  wire        oe_n,
  input  wire        adc_start,
  output wire        pad,
  output reg  [15:0] hi_len_ff,
  output reg  [15:0] per_len_ff,
  output reg  [15:0] hi_tot_ff,
  output reg  [15:0] lo_tot_ff,
  output reg  [15:0] adc_cnt_ff
);
  reg        last_ff;
  reg [15:0] run_hi_ff;
  reg [15:0] run_per_ff;
  wire       rise = pad && !last_ff;
  // undriven pad is pulled low, never left at the last driven level
  assign pad = oe_n ? 1'b0 : pin;
  initial begin
    {last_ff, run_hi_ff, run_per_ff, hi_len_ff, per_len_ff, hi_tot_ff, lo_tot_ff, adc_cnt_ff} = 0;
  end
  always @(posedge clk) begin
    last_ff <= pad;
    run_per_ff <= rise ? 16'h1 : run_per_ff + 16'h1;
    run_hi_ff <= rise ? 16'h1 : run_hi_ff + {15'h0, pad};
    if (rise) per_len_ff <= run_per_ff;
    if (!pad && last_ff) hi_len_ff <= run_hi_ff;
    hi_tot_ff <= hi_tot_ff + {15'h0, pad};
    lo_tot_ff <= lo_tot_ff + {15'h0, !pad};
    adc_cnt_ff <= adc_cnt_ff + {15'h0, adc_start};
  end
endmodule

// ==== sim/cpwm_unit_bench.sv ====
// self-checking bench of the compare and pwm unit
`timescale 1ns/1ns
module cpwm_unit_bench;
  reg          clk, rst_n, psel, penable, pwrite, adc_en, loc_cfg, er;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata;
  reg  [7:0]   rd;
  wire [31:0]  prdata;
  wire         pready, pslverr, pin, oe_n, adc_start, irq, pad;
  wire [15:0]  hi_len, per_len, hi_tot, lo_tot, adc_cnt;
  integer      failures, samples_checked, i, t;
  integer      cyc = 0;
  localparam [19:0]  modes = 20'h89ba8;
  localparam [103:0] ridx  = {8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h86, 8'h8c, 8'h92};

  cpwm_unit u_cpwm_unit (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ADC_ENABLE(adc_en), .PIN_LOCATION_CONFIG(loc_cfg), .UNIT_OUTPUT_PIN(pin),
    .UNIT_PIN_OE_N(oe_n), .ADC_START(adc_start), .PERIPH_IRQ(irq));
  cpwm_pin_model u_cpwm_pin_model (.clk(clk), .pin(pin), .oe_n(oe_n), .adc_start(adc_start), .pad(pad),
    .hi_len_ff(hi_len), .per_len_ff(per_len), .hi_tot_ff(hi_tot), .lo_tot_ff(lo_tot), .adc_cnt_ff(adc_cnt));

  // ------------
  // tasks
  // ------------
  task check(input [95:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // request held until ready is sampled high, then released
  task apb(input w, input [7:0] idx, input [7:0] wd);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rdc(input [95:0] nm, input [7:0] idx, input [7:0] exp);
    begin
      apb(1'b0, idx, 8'h00);
      check(nm, {8'h0, rd}, {8'h0, exp});
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task print_verdict;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, adc_en, loc_cfg, er, paddr, pwdata, rd} = 0;
    {failures, samples_checked, t} = 0;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    for (i = 0; i < 13; i = i + 1)
      rdc("reset", ridx[8*i +: 8], (ridx[8*i +: 8] == 8'h86 || ridx[8*i +: 8] == 8'h92) ? 8'hff : 8'h00);
    apb(1'b1, 8'h01, 8'h5a);
    check("wr_err", er, 1'b1);
    rdc("unmap", 8'h01, 8'h00);
    check("rd_err", er, 1'b1);
    apb(1'b1, 8'h17, 8'hff);
    rdc("ctl_rw", 8'h17, 8'h3f);
    apb(1'b1, 8'h0c, 8'hff);
    rdc("flg_rw", 8'h0c, 8'h7f);
    apb(1'b1, 8'h17, 8'h00);
    apb(1'b1, 8'h86, 8'hf7);
    tick(1);
    check("oe_b0", oe_n, 1'b1);
    loc_cfg <= 1'b1;
    tick(2);
    check("oe_b3", oe_n, 1'b0);
    loc_cfg <= 1'b0;
    // compare: set, flag only, special, clear, set again
    adc_en <= 1'b1;
    apb(1'b1, 8'h86, 8'hfe);
    apb(1'b1, 8'h0b, 8'hc0);
    apb(1'b1, 8'h8c, 8'h04);
    apb(1'b1, 8'h15, 8'h10);
    apb(1'b1, 8'h16, 8'h00);
    apb(1'b1, 8'h10, 8'h01);
    for (i = 0; i < 5; i = i + 1) begin
      t = adc_cnt;
      apb(1'b1, 8'h0f, 8'h00);
      apb(1'b1, 8'h0e, 8'h00);
      apb(1'b1, 8'h0c, 8'h00);
      apb(1'b1, 8'h17, {4'h0, modes[4*i +: 4]});
      rd = 8'h00;
      while (rd[2] !== 1'b1)
        apb(1'b0, 8'h0c, 8'h00);
      check("flags", rd, 8'h04);
      tick(1);
      check("pin", pad, i != 3);
      check("irq", irq, 1'b1);
      if (i == 2) begin
        check("adc", adc_cnt - t[15:0], 16'h1);
        apb(1'b0, 8'h0e, 8'h00);
        check("t1_clr", rd < 8'h10, 1'b1);
      end
    end
    apb(1'b1, 8'h17, 8'h00);
    apb(1'b1, 8'h8c, 8'h00);
    tick(1);
    check("pin_off", pad, 1'b0);
    check("irq_mask", irq, 1'b0);
    // pwm at prescale 1, 4 and 16 with postscale 16
    apb(1'b1, 8'h10, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b1, 8'h92, 8'h03);
      apb(1'b1, 8'h15, 8'h01);
      apb(1'b1, 8'h12, 8'h7c | i[7:0]);
      apb(1'b1, 8'h17, 8'h2c);
      tick(700);
      check("period", per_len, 16'h10 << (2 * i));
      check("high", hi_len, 16'h6 << (2 * i));
    end
    rdc("duty_act", 8'h16, 8'h01);
    apb(1'b1, 8'h16, 8'h55);
    rdc("hi_ro", 8'h16, 8'h01);
    apb(1'b1, 8'h15, 8'h10);
    tick(600);
    t = lo_tot;
    tick(600);
    check("no_clear", lo_tot - t[15:0], 16'h0);
    apb(1'b1, 8'h17, 8'h00);
    tick(1);
    check("pwm_off", pad, 1'b0);
    apb(1'b1, 8'h15, 8'h00);
    apb(1'b1, 8'h17, 8'h0c);
    tick(600);
    t = hi_tot;
    tick(600);
    check("zero_duty", hi_tot - t[15:0], 16'h0);
    print_verdict;
  end
endmodule

// ==== sim/cpwm_unit_properties.sv ====
// port-level checks of the compare and pwm unit
`timescale 1ns/1ns
module cpwm_unit_properties #(
  parameter ADDR_W = 12
) (
  input wire              CLK,
  input wire              RESET_N,
  input wire              PSEL,
  input wire              PENABLE,
  input wire              PWRITE,
  input wire [ADDR_W-1:0] PADDR,
  input wire [31:0]       PWDATA,
  input wire [31:0]       PRDATA,
  input wire              PREADY,
  input wire              PSLVERR,
  input wire              ADC_ENABLE,
  input wire              PIN_LOCATION_CONFIG,
  input wire              UNIT_OUTPUT_PIN,
  input wire              UNIT_PIN_OE_N,
  input wire              ADC_START,
  input wire              PERIPH_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ------------
  // bus steps
  // ------------
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence wr_s(a);
    PSEL && PENABLE && PREADY && PWRITE && PADDR == a;
  endsequence
  setup_ready_a: assert property (setup_s |=> PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  unmapped_err_a: assert property (setup_s ##0 !PWRITE && PADDR == 12'h004 |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped read not refused");
  adc_pulse_a: assert property (ADC_START |=> !ADC_START)
    else $error("converter start longer than one cycle");
  adc_gated_a: assert property (ADC_START |-> $past(ADC_ENABLE))
    else $error("converter start while converter off");
  ctl_zero_pin_a: assert property (wr_s(12'h05c) ##0 PWDATA[7:0] == 8'h00 |=> ##1 !UNIT_OUTPUT_PIN)
    else $error("pin not low after control cleared");
  oe_follow_a: assert property (wr_s(12'h218) ##0 !PIN_LOCATION_CONFIG |=> ##1 UNIT_PIN_OE_N == $past(PWDATA[0], 2))
    else $error("pin enable does not follow direction bit");
  irq_gate_a: assert property (wr_s(12'h230) ##0 PWDATA[7:0] == 8'h00 |=> ##1 !PERIPH_IRQ)
    else $error("interrupt raised with all enables clear");
endmodule

bind cpwm_unit cpwm_unit_properties #(.ADDR_W(ADDR_W)) u_cpwm_unit_properties (
  .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ADC_ENABLE(ADC_ENABLE), .PIN_LOCATION_CONFIG(PIN_LOCATION_CONFIG),
  .UNIT_OUTPUT_PIN(UNIT_OUTPUT_PIN), .UNIT_PIN_OE_N(UNIT_PIN_OE_N),
  .ADC_START(ADC_START), .PERIPH_IRQ(PERIPH_IRQ));
